//--- design/evpd_exception_vector_priority_decoder.sv
// Design decisions made here: the APB interface to the registers and the register offsets.
`include "evpd_params.svh"

// How it works
// - Base byte register, resets to FF
// - Base register readable and writable anytime
// - Reset vectors fixed at top addresses
// - Debug active forces base byte FF
// - Highest vector address wins among pending
// - I request needs enable, clear I, no NMI
// - Non-I outrank I; X preempts when X clear
// - Vector resolved when CPU fetches it
// - No request left gives spurious vector
// - Reset vector order FFFE, FFFC, FFFA
// - Trap F8, software F6, X F4, pin F2
// - Device I sources F0 down to 80
// - Base is register byte then zero byte
// - I handler nests only after mask cleared
// - I requests wake stop on enable and clear I; NMI ignored
// - Wake set path asynchronous, no sampling; clear is clocked
// - X wakes stop even when X masked
// - Software interrupt and trap may nest
// - Decoder clock stops in stop mode
module evpd_exception_vector_priority_decoder #(
  parameter int NUM_IMASK = 58
) (
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Exception sources
  input wire evpd_pkg::evpd_rst_req_t reset_req,
  input wire evpd_pkg::evpd_nmi_req_t nmi_req,
  input wire logic pin_req,
  input wire logic [NUM_IMASK-2:0] imask_req,
  input wire logic [NUM_IMASK-2:0] imask_local_en,
  input wire evpd_pkg::evpd_cpu_flags_t cpu_condition_flags,
  input wire logic background_debug,
  // CPU vector fetch
  input wire logic vec_req,
  output logic [15:0] vec_addr,
  output logic [2:0] vec_src,
  // Stop-mode wake
  input wire logic stop_mode,
  output logic wake_req,
  output logic wake_no_service
);

  // ****************************************
  // Input synchronisers
  // ****************************************
  // Requests come from other logic on pins; two flops each.
  localparam int SW = 3 + 3 + 1 + (NUM_IMASK - 1) * 2 + 2 + 1 + 1;
  logic [SW-1:0] raw_in;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;

  assign raw_in = {reset_req, nmi_req, pin_req, imask_req, imask_local_en,
                   cpu_condition_flags, background_debug, vec_req};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  evpd_pkg::evpd_rst_req_t s_rst;
  evpd_pkg::evpd_nmi_req_t s_nmi;
  logic s_pin;
  logic [NUM_IMASK-2:0] s_ireq;
  logic [NUM_IMASK-2:0] s_ien;
  evpd_pkg::evpd_cpu_flags_t s_flags;
  logic s_dbg;
  logic s_vreq;

  assign {s_rst, s_nmi, s_pin, s_ireq, s_ien, s_flags, s_dbg, s_vreq} = sync2_q;

  // ****************************************
  // Registers
  // ****************************************
  logic [7:0] vector_base_upper_byte_q;
  logic apb_wr;
  logic apb_rd;

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vector_base_upper_byte_q <= `EVPD_VBR_RESET;
    end else if (apb_wr && paddr == `EVPD_VBR_OFFSET) begin
      vector_base_upper_byte_q <= pwdata[7:0];
    end
  end

  // Single-cycle access: ready rises in the access phase.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok(paddr);
    end
  end

  function automatic logic addr_ok(input logic [11:0] a);
    addr_ok = (a == `EVPD_VBR_OFFSET) || (a == `EVPD_CTRL_OFFSET) ||
              (a == `EVPD_STAT_OFFSET);
  endfunction

  // ****************************************
  // Priority resolution
  // ****************************************
  logic [7:0] base_byte;
  logic any_nmi;
  logic [7:0] imask_ofs;
  logic imask_hit;
  logic [15:0] vec_d;
  evpd_pkg::evpd_src_t src_d;

  // Debug firmware must reach every handler from a fixed page.
  assign base_byte = s_dbg ? `EVPD_DEBUG_BASE : vector_base_upper_byte_q;
  // A pending X request blocks I sources even while its own mask is set
  assign any_nmi = s_nmi.trap || s_nmi.software_interrupt || s_nmi.xreq;

  // Index 0 is the highest device source at F0; step of two per source.
  always_comb begin
    imask_ofs = 8'h00;
    imask_hit = 1'b0;
    for (int i = NUM_IMASK - 2; i >= 0; i--) begin
      if (s_ireq[i] && s_ien[i]) begin
        imask_hit = 1'b1;
        imask_ofs = `EVPD_OFS_IMASK_TOP - 8'(2 * i);
      end
    end
  end

  function automatic logic [15:0] mk_vec(input logic [7:0] b, input logic [7:0] o);
    mk_vec = {b, o};
  endfunction

  always_comb begin
    vec_d = mk_vec(base_byte, `EVPD_OFS_SPURIOUS);
    src_d = evpd_pkg::EVPD_SRC_SPURIOUS;
    // Resets first, then non-maskables, then I sources
    if (s_rst.main) begin
      vec_d = `EVPD_VEC_RST_MAIN;
      src_d = evpd_pkg::EVPD_SRC_RESET;
    end else if (s_rst.clkmon) begin
      vec_d = `EVPD_VEC_RST_CLKMON;
      src_d = evpd_pkg::EVPD_SRC_RESET;
    end else if (s_rst.wdog) begin
      vec_d = `EVPD_VEC_RST_WDOG;
      src_d = evpd_pkg::EVPD_SRC_RESET;
    end else if (s_nmi.trap) begin
      // No in-service lockout on trap or software requests
      vec_d = mk_vec(base_byte, `EVPD_OFS_TRAP);
      src_d = evpd_pkg::EVPD_SRC_NMI;
    end else if (s_nmi.software_interrupt) begin
      vec_d = mk_vec(base_byte, `EVPD_OFS_SWI);
      src_d = evpd_pkg::EVPD_SRC_NMI;
    end else if (s_nmi.xreq && !s_flags.xflag) begin
      vec_d = mk_vec(base_byte, `EVPD_OFS_XREQ);
      src_d = evpd_pkg::EVPD_SRC_NMI;
    end else if (!s_flags.iflag && !any_nmi) begin
      // CPU sets the mask on entry, so I sources nest only after clearing
      if (s_pin) begin
        vec_d = mk_vec(base_byte, `EVPD_OFS_PIN);
        src_d = evpd_pkg::EVPD_SRC_IMASK;
      end else if (imask_hit) begin
        vec_d = mk_vec(base_byte, imask_ofs);
        src_d = evpd_pkg::EVPD_SRC_IMASK;
      end
    end
  end

  // ****************************************
  // Vector output
  // ****************************************
  // Captured on strobe rise, so later arrivals do not change it; held while high.
  logic vreq_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      vreq_q <= 1'b0;
      vec_addr <= 16'h0000;
      vec_src <= 3'h0;
    end else begin
      vreq_q <= s_vreq;
      if (s_vreq && !vreq_q) begin
        vec_addr <= vec_d;
        vec_src <= 3'(src_d);
      end
    end
  end

  // ****************************************
  // Status read path
  // ****************************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (apb_rd && !penable) begin
      case (paddr)
        `EVPD_VBR_OFFSET: prdata <= {24'h000000, vector_base_upper_byte_q};
        `EVPD_CTRL_OFFSET: prdata <= {29'h0, stop_mode, s_flags.xflag, s_flags.iflag};
        `EVPD_STAT_OFFSET: prdata <= {16'h0000, vec_addr};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************
  // Stop-mode wake
  // ****************************************
  // Clock is gated in stop, so the wake level is a latch set by the
  // raw request edge itself and cleared at a clock edge once the set term drops.
  logic iwake_async;
  logic wake_set;

  assign iwake_async = !cpu_condition_flags.iflag &&
                       (pin_req || |(imask_req & imask_local_en));
  assign wake_set = stop_mode && (iwake_async || nmi_req.xreq);

  // Asynchronous set path from the raw request
  always_ff @(posedge core_clk or negedge rst_n or posedge wake_set) begin
    if (!rst_n) begin
      wake_req <= 1'b0;
    end else if (wake_set) begin
      wake_req <= 1'b1;
    end else begin
      wake_req <= 1'b0;
    end
  end

  // Own set term keeps the asynchronous branch a constant load
  logic xonly_set;

  assign xonly_set = stop_mode && nmi_req.xreq && cpu_condition_flags.xflag && !iwake_async;

  always_ff @(posedge core_clk or negedge rst_n or posedge xonly_set) begin
    if (!rst_n) begin
      wake_no_service <= 1'b0;
    end else if (xonly_set) begin
      wake_no_service <= 1'b1;
    end else begin
      wake_no_service <= 1'b0;
    end
  end

endmodule

//--- design/evpd_params.svh
`ifndef EVPD_PARAMS_SVH
`define EVPD_PARAMS_SVH
// ****************************************
// Register map and reset values
// ****************************************
`define EVPD_VBR_OFFSET 12'h000
`define EVPD_CTRL_OFFSET 12'h004
`define EVPD_STAT_OFFSET 12'h008
`define EVPD_VBR_RESET 8'hFF
// ****************************************
// Vector offsets
// ****************************************
`define EVPD_VEC_RST_MAIN 16'hFFFE
`define EVPD_VEC_RST_CLKMON 16'hFFFC
`define EVPD_VEC_RST_WDOG 16'hFFFA
`define EVPD_OFS_TRAP 8'hF8
`define EVPD_OFS_SWI 8'hF6
`define EVPD_OFS_XREQ 8'hF4
`define EVPD_OFS_PIN 8'hF2
`define EVPD_OFS_IMASK_TOP 8'hF0
`define EVPD_OFS_SPURIOUS 8'h80
`define EVPD_DEBUG_BASE 8'hFF
// Control register fields
`define EVPD_CTRL_IFLAG_BIT 0
`define EVPD_CTRL_XFLAG_BIT 1
`define EVPD_CTRL_STOP_BIT 2
`endif

//--- design/evpd_pkg.sv
package evpd_pkg;
  typedef struct packed {
    logic main;
    logic clkmon;
    logic wdog;
  } evpd_rst_req_t;

  typedef struct packed {
    logic trap;
    logic software_interrupt;
    logic xreq;
  } evpd_nmi_req_t;

  typedef struct packed {
    logic iflag;
    logic xflag;
  } evpd_cpu_flags_t;

  typedef enum logic [2:0] {
    EVPD_SRC_NONE,
    EVPD_SRC_RESET,
    EVPD_SRC_NMI,
    EVPD_SRC_IMASK,
    EVPD_SRC_SPURIOUS
  } evpd_src_t;
endpackage

//--- verif/evpd_checker_properties.sv
module evpd_checker #(
  parameter int NUM_IMASK = 58
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire evpd_pkg::evpd_rst_req_t reset_req,
  input wire evpd_pkg::evpd_nmi_req_t nmi_req,
  input wire logic pin_req,
  input wire logic [NUM_IMASK-2:0] imask_req,
  input wire evpd_pkg::evpd_cpu_flags_t cpu_condition_flags,
  input wire logic background_debug,
  input wire logic vec_req,
  input wire logic [15:0] vec_addr,
  input wire logic stop_mode,
  input wire logic wake_req,
  input wire logic wake_no_service
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic none_pending;
  assign none_pending = reset_req == 3'h0 && nmi_req == 3'h0 && !pin_req && imask_req == '0;
  // Sources held over the whole fetch, so the capture cannot race a change
  apb_answer_a: assert property (psel && !penable |=> pready) else $error("no answer");
  apb_pulse_a: assert property (pready |=> !pready) else $error("answer held");
  apb_refuse_a: assert property (psel && !penable && paddr > 12'h008 |=> pslverr)
    else $error("unmapped accepted");
  reset_vec_a: assert property ($rose(vec_req) ##0 (vec_req && reset_req.main)[*5]
    |=> vec_addr == 16'hFFFE) else $error("reset vector wrong");
  spur_vec_a: assert property ($rose(vec_req) ##0 (vec_req && none_pending)[*5]
    |=> vec_addr[7:0] == 8'h80) else $error("spurious vector wrong");
  debug_base_a: assert property ($rose(vec_req) ##0 (vec_req && background_debug)[*5]
    |=> vec_addr[15:8] == 8'hFF) else $error("debug base wrong");
  trap_vec_a: assert property ($rose(vec_req) ##0 (vec_req && nmi_req.trap && reset_req == 3'h0)[*5]
    |=> vec_addr[7:0] == 8'hF8) else $error("trap vector wrong");
  x_wake_a: assert property (stop_mode && nmi_req.xreq |-> wake_req) else $error("no wake");
  i_nowake_a: assert property ((stop_mode && cpu_condition_flags.iflag && reset_req == 3'h0
    && nmi_req == 3'h0)[*2] |-> !wake_req) else $error("masked wake");
  x_noservice_a: assert property ((stop_mode && nmi_req == 3'h1 && cpu_condition_flags.xflag
    && !pin_req && imask_req == '0)[*2] |-> wake_no_service) else $error("service on X wake");
endmodule

bind evpd_exception_vector_priority_decoder evpd_checker #(.NUM_IMASK(NUM_IMASK)) evpd_checker_i (.*);

//--- verif/evpd_cpu_model.sv
module evpd_cpu_model (
  input wire logic core_clk,
  output logic vec_req,
  input wire logic [15:0] vec_addr,
  input wire logic [2:0] vec_src
);
  timeunit 1ns;
  timeprecision 1ns;
  initial vec_req = 1'b0;
  // No ready exists, so the strobe spans the three-edge capture with margin
  task automatic fetch(output logic [18:0] got);
    @(posedge core_clk);
    vec_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    got = {vec_src, vec_addr};
    vec_req <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule

//--- verif/evpd_exception_vector_priority_decoder_test.sv
module evpd_exception_vector_priority_decoder_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NI = 16;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, vec_req, wake_req;
  logic pin_req = 1'b0, background_debug = 1'b0, stop_mode = 1'b0, wake_no_service;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h92791DF9;
  logic [NI-2:0] imask_req = '0, imask_local_en = '0;
  logic [15:0] vec_addr;
  logic [2:0] vec_src;
  logic [18:0] got;
  logic rd_err = 1'b0;
  logic [7:0] base = 8'hFF;
  evpd_pkg::evpd_rst_req_t reset_req = 3'h0;
  evpd_pkg::evpd_nmi_req_t nmi_req = 3'h0;
  evpd_pkg::evpd_cpu_flags_t cpu_condition_flags = 2'h3;
  int bad_count = 0, comparisons = 0;
  always #5 core_clk = ~core_clk;
  evpd_exception_vector_priority_decoder #(.NUM_IMASK(NI))
    evpd_exception_vector_priority_decoder_i (.*);
  evpd_cpu_model evpd_cpu_model_i (.*);
  // ****
  // Helpers
  // ****
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Answer is looked at mid-cycle, ahead of the edge that completes it
    @(negedge core_clk);
    while (!pready && n < 8) begin
      @(negedge core_clk);
      n++;
    end
    if (!pready) begin
      bad_count++;
      tally_and_finish();
    end
    rd = prdata;
    rd_err = pslverr;
    @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Mask flags high mean masked; X pending blocks I sources even while masked
  function automatic logic [18:0] expv();
    logic [7:0] b;
    b = background_debug ? 8'hFF : base;
    if (reset_req.main) return {3'h1, 16'hFFFE};
    if (reset_req.clkmon) return {3'h1, 16'hFFFC};
    if (reset_req.wdog) return {3'h1, 16'hFFFA};
    if (nmi_req.trap) return {3'h2, b, 8'hF8};
    if (nmi_req.software_interrupt) return {3'h2, b, 8'hF6};
    if (nmi_req.xreq && !cpu_condition_flags.xflag) return {3'h2, b, 8'hF4};
    if (!cpu_condition_flags.iflag && !nmi_req.xreq) begin
      if (pin_req) return {3'h3, b, 8'hF2};
      for (int i = 0; i < NI - 1; i++) begin
        if (imask_req[i] && imask_local_en[i]) return {3'h3, b, 8'hF0 - 8'(2 * i)};
      end
    end
    return {3'h4, b, 8'h80};
  endfunction
  // ****
  // Sequence
  // ****
  initial begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0000_00FF);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b1, 12'h00C, 32'h0000_0012);
    chk({31'h0, rd_err}, 32'h1);
    repeat (80) begin
      base = 8'(xs());
      apb(1'b1, 12'h000, {24'h0, base});
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, {24'h0, base});
      reset_req <= (xs() % 6 == 0) ? 3'(xs()) : 3'h0;
      nmi_req <= 3'(xs() & xs());
      pin_req <= xs() % 4 == 0;
      imask_req <= (NI - 1)'(xs() & xs());
      imask_local_en <= (NI - 1)'(xs());
      cpu_condition_flags <= 2'(xs());
      background_debug <= xs() % 5 == 0;
      evpd_cpu_model_i.fetch(got);
      chk(32'(got), 32'(expv()));
    end
    reset_req <= 3'h0;
    nmi_req <= 3'h0;
    pin_req <= 1'b0;
    imask_req <= '1;
    imask_local_en <= '1;
    cpu_condition_flags <= 2'h3;
    stop_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk(32'(wake_req), 32'h0);
    imask_req <= '0;
    nmi_req <= 3'h1;
    repeat (3) @(posedge core_clk);
    chk(32'({wake_req, wake_no_service}), 32'h3);
    nmi_req <= 3'h0;
    imask_req <= '1;
    cpu_condition_flags <= 2'h1;
    repeat (3) @(posedge core_clk);
    chk(32'(wake_req), 32'h1);
    tally_and_finish();
  end
endmodule
